// file: hdl/cfgc_checker.sv
// cfgc_checker: shadow stack and landing marker enforcement with register slave
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RULE1 - with shadow stacks on, task switch needs 32-bit segment, not virtual-8086; code checks this on call task switches only
// RULE2 - new shadow pointer read at segment offset 104; segment at least 108 bytes
// RULE3 - new shadow pointer 8-byte aligned and pointing at supervisor token
// RULE4 - call/event task switch pushes old pointer, selector, linear ip on new stack
// RULE5 - return task switch reloads pointer from old task's shadow stack
// RULE6 - return task switch compares saved selector/ip, far-return fault on mismatch
// RULE7 - restore validates token at operand, then pointer becomes token address
// RULE8 - restore token: pointer in 63:2, bit 1 zero, bit 0 mode
// RULE9 - restore replaces token with previous-pointer token of old pointer
// RULE10 - previous-pointer token: pointer 63:2, bit 1 one, bit 0 mode
// RULE11 - save-previous has no operand, needs previous-pointer token at top
// RULE12 - save-previous writes restore token in slot below recorded pointer
// RULE13 - save-previous then pops previous-pointer token, pointer advances
// RULE14 - block return target when addresses speculative or disagree, unless predicted
// RULE15 - while tracking, non-marker after indirect branch raises fault
// RULE16 - track register/memory and far memory forms, exclude direct forms
// RULE17 - landing markers change no register or flag state
// RULE18 - two trackers, user and supervisor, idle after reset
// RULE19 - idle on other instructions, awaiting after indirect branch
// RULE20 - awaiting checks mode marker; fault or pass if legacy allowed
// RULE21 - higher priority events first, tracker keeps state
// RULE22 - missing-landing fault reports ip of branch target instruction
// RULE23 - supervisor token: own address 63:3, bits 2:1 zero, bit 0 busy; code neither checks nor sets bit 0
// RULE24 - user tracker at privilege 3, supervisor tracker below
// RULE25 - bad token leaves pointer and memory unchanged, raises fault
module cfgc_checker
	import cfgc_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite slave
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output var  logic        s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output var  logic        s_wready,
	output var  logic [1:0]  s_bresp,
	output var  logic        s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [7:0]  s_araddr,
	input  wire logic        s_arvalid,
	output var  logic        s_arready,
	output var  logic [31:0] s_rdata,
	output var  logic [1:0]  s_rresp,
	output var  logic        s_rvalid,
	input  wire logic        s_rready,
	// retiring instruction stream
	input  wire cfgc_op_t    op,
	input  wire logic        op_valid,
	output var  logic        op_ready,
	// shadow stack memory
	output var  cfgc_mreq_t  mreq,
	input  wire logic        mem_ack,
	input  wire logic [63:0] mem_rdata,
	// results
	output var  logic        fault,
	output var  cfgc_flt_t   fault_code,
	output var  logic [63:0] fault_ip,
	output var  logic        ret_allow
);
	// ****************************************************************
	// register slave
	// ****************************************************************
	logic        awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
	logic        arready_q, arready_d, rvalid_q, rvalid_d, aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
	logic [7:0]  awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic [3:0]  wstrb_q, wstrb_d;
	logic [2:0]  ctrl_q, ctrl_d;
	logic        we_lo, we_hi;
	logic [63:0] ssp_q, ssp_d, fip_q, fip_d;
	cfgc_trk_t   trk_q [2], trk_d [2];
	cfgc_flt_t   code_q, code_d;

	typedef enum {S_IDLE, S_TS_TSS, S_TS_TOK, S_TS_PUSH, S_IR_POP,
		S_RS_RD, S_RS_WR, S_SP_RD, S_SP_WR} cfgc_st_t;
	cfgc_st_t st_q, st_d;

	function automatic logic [31:0] cfgc_merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction : cfgc_merge

	// write address and data are latched apart so either may come first
	always_comb begin
		awready_d = awready_q;
		wready_d  = wready_q;
		aw_have_d = aw_have_q;
		w_have_d  = w_have_q;
		awaddr_d  = awaddr_q;
		wdata_d   = wdata_q;
		wstrb_d   = wstrb_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		arready_d = arready_q;
		rvalid_d  = rvalid_q;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		ctrl_d    = ctrl_q;
		we_lo     = 1'b0;
		we_hi     = 1'b0;
		if (s_awvalid && awready_q) begin
			aw_have_d = 1'b1;
			awready_d = 1'b0;
			awaddr_d  = s_awaddr;
		end
		if (s_wvalid && wready_q) begin
			w_have_d = 1'b1;
			wready_d = 1'b0;
			wdata_d  = s_wdata;
			wstrb_d  = s_wstrb;
		end
		if (aw_have_q && w_have_q && !bvalid_q) begin
			bvalid_d  = 1'b1;
			bresp_d   = CFGC_RESP_OKAY;
			aw_have_d = 1'b0;
			w_have_d  = 1'b0;
			case (awaddr_q)
				CFGC_OFF_CTRL:   ctrl_d = 3'(cfgc_merge({29'h0, ctrl_q}, wdata_q, wstrb_q));
				CFGC_OFF_SSP_LO: we_lo = 1'b1;
				CFGC_OFF_SSP_HI: we_hi = 1'b1;
				CFGC_OFF_STATUS, CFGC_OFF_FIP_LO: bresp_d = CFGC_RESP_OKAY;
				default:         bresp_d = CFGC_RESP_SLVERR;
			endcase
		end
		if (bvalid_q && s_bready) begin
			bvalid_d  = 1'b0;
			awready_d = 1'b1;
			wready_d  = 1'b1;
		end
		if (s_arvalid && arready_q) begin
			arready_d = 1'b0;
			rvalid_d  = 1'b1;
			rresp_d   = CFGC_RESP_OKAY;
			case (s_araddr)
				CFGC_OFF_CTRL:   rdata_d = {29'h0, ctrl_q};
				CFGC_OFF_SSP_LO: rdata_d = ssp_q[31:0];
				CFGC_OFF_SSP_HI: rdata_d = ssp_q[63:32];
				CFGC_OFF_STATUS: rdata_d = {24'h0, st_q == S_IDLE, code_q,
					trk_q[1] == TRK_AWAIT, trk_q[0] == TRK_AWAIT, 2'h0};
				CFGC_OFF_FIP_LO: rdata_d = fip_q[31:0];
				default: begin
					rdata_d = 32'h0;
					rresp_d = CFGC_RESP_SLVERR;
				end
			endcase
		end
		if (rvalid_q && s_rready) begin
			rvalid_d  = 1'b0;
			arready_d = 1'b1;
		end
	end

	// slave registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q  <= 1'b1;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= CFGC_RESP_OKAY;
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0;
			rresp_q   <= CFGC_RESP_OKAY;
			ctrl_q    <= CFGC_CTRL_RST;
		end else begin
			awready_q <= awready_d;
			wready_q  <= wready_d;
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
			awaddr_q  <= awaddr_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
			ctrl_q    <= ctrl_d;
		end
	end

	// ****************************************************************
	// shadow stack engine and landing trackers
	// ****************************************************************
	cfgc_op_t    op_q, op_d;
	cfgc_mreq_t  mreq_q, mreq_d;
	logic [63:0] tmp_q, tmp_d, val_q, val_d, old_ptr;
	logic [1:0]  cnt_q, cnt_d;
	logic        fault_q, fault_d, ret_q, ret_d, opr_q, opr_d;
	logic        take, sel, land_ok, tracked, skip, ss_en, trk_en;

	assign ss_en   = ctrl_q[CFGC_CTRL_SS_EN];
	assign trk_en  = ctrl_q[CFGC_CTRL_TRK_EN];
	assign take    = op_valid && opr_q;
	assign sel     = (op.current_privilege_level == CFGC_CPL_USER);                           // [RULE24]
	assign land_ok = (op.kind == OP_LAND64 && op.mode64) ||
		(op.kind == OP_LAND32 && !op.mode64);                             // [RULE15]
	assign tracked = (op.kind == OP_IND_BRANCH) &&
		(op.form == BR_RM || op.form == BR_FAR_MEM);                      // [RULE16]
	assign old_ptr = {mem_rdata[63:2], 2'b00};

	// one instruction is taken per idle cycle; memory steps hold off the next
	always_comb begin
		st_d     = st_q;
		op_d     = op_q;
		tmp_d    = tmp_q;
		val_d    = val_q;
		cnt_d    = cnt_q;
		ssp_d    = ssp_q;
		fip_d    = fip_q;
		code_d   = code_q;
		trk_d    = trk_q;
		ret_d    = ret_q;
		fault_d  = 1'b0;
		skip     = 1'b0;
		mreq_d   = mreq_q;
		if (mem_ack) begin
			mreq_d.valid = 1'b0;
		end
		if (we_lo) begin
			ssp_d[31:0] = cfgc_merge(ssp_q[31:0], wdata_q, wstrb_q);
		end
		if (we_hi) begin
			ssp_d[63:32] = cfgc_merge(ssp_q[63:32], wdata_q, wstrb_q);
		end
		case (st_q)
			S_IDLE: begin
				if (take) begin
					op_d = op;
					if (trk_en && trk_q[sel] == TRK_AWAIT) begin
						if (op.hi_evt) begin
							skip = 1'b1;                                  // [RULE21]
						end else if (!land_ok && !ctrl_q[CFGC_CTRL_LEGACY]) begin
							skip         = 1'b1;                          // [RULE20]
							fault_d      = 1'b1;
							code_d       = FLT_LANDING;
							fip_d        = op.ip;                         // [RULE22]
							trk_d[sel]   = TRK_IDLE;
						end else begin
							trk_d[sel] = TRK_IDLE;                        // [RULE17]
						end
					end
					if (!skip && trk_en) begin
						trk_d[sel] = tracked ? TRK_AWAIT : trk_d[sel];    // [RULE19]
					end
					if (!skip && ss_en) begin
						case (op.kind)
							OP_TASK_CALL: begin
								if (!op.tss32 || op.vm86 || op.tss_size < CFGC_TSS_MIN_SZ) begin
									fault_d = 1'b1;                       // [RULE1]
									code_d  = FLT_TASK;
									fip_d   = op.ip;
								end else begin
									mreq_d = '{1'b1, 1'b0,
										{32'h0, op.tss_base} + CFGC_TSS_SSP_OFF, 64'h0}; // [RULE2]
									st_d   = S_TS_TSS;
								end
							end
							OP_TASK_IRET: begin
								mreq_d = '{1'b1, 1'b0, ssp_q, 64'h0};     // [RULE5]
								cnt_d  = 2'h0;
								st_d   = S_IR_POP;
							end
							OP_RESTORE: begin
								mreq_d = '{1'b1, 1'b0, op.addr, 64'h0};   // [RULE7]
								st_d   = S_RS_RD;
							end
							OP_SAVEPREV: begin
								mreq_d = '{1'b1, 1'b0, ssp_q, 64'h0};     // [RULE11]
								st_d   = S_SP_RD;
							end
							OP_RET: begin
								ret_d = !((op.ret_spec || op.ret_mismatch) && !op.ret_pred); // [RULE14]
							end
							default: ret_d = ret_q;
						endcase
					end else if (!skip && op.kind == OP_RET) begin
						ret_d = 1'b1;
					end
				end
			end
			S_TS_TSS: if (mem_ack) begin
				tmp_d = {32'h0, mem_rdata[31:0]};
				if (mem_rdata[2:0] != 3'h0) begin
					fault_d = 1'b1;                                       // [RULE3]
					code_d  = FLT_TASK;
					fip_d   = op_q.ip;
					st_d    = S_IDLE;
				end else begin
					mreq_d = '{1'b1, 1'b0, {32'h0, mem_rdata[31:0]}, 64'h0};
					st_d   = S_TS_TOK;
				end
			end
			S_TS_TOK: if (mem_ack) begin
				if (mem_rdata[63:3] == tmp_q[63:3] && mem_rdata[2:1] == 2'h0) begin // [RULE23]
					tmp_d  = tmp_q - CFGC_SLOT;
					mreq_d = '{1'b1, 1'b1, tmp_q - CFGC_SLOT, {48'h0, op_q.out_cs}}; // [RULE4]
					cnt_d  = 2'h0;
					st_d   = S_TS_PUSH;
				end else begin
					fault_d = 1'b1;                                       // [RULE3]
					code_d  = FLT_TOKEN;
					fip_d   = op_q.ip;
					st_d    = S_IDLE;
				end
			end
			S_TS_PUSH: if (mem_ack) begin
				cnt_d = cnt_q + 2'h1;
				if (cnt_q == 2'h2) begin
					ssp_d = tmp_q;
					st_d  = S_IDLE;
				end else begin
					tmp_d  = tmp_q - CFGC_SLOT;
					mreq_d = '{1'b1, 1'b1, tmp_q - CFGC_SLOT,
						(cnt_q == 2'h0) ? op_q.out_lip : ssp_q};          // [RULE4]
				end
			end
			S_IR_POP: if (mem_ack) begin
				cnt_d = cnt_q + 2'h1;
				if (cnt_q == 2'h0) begin
					tmp_d = mem_rdata;
				end else if (cnt_q == 2'h1) begin
					val_d = mem_rdata;
				end
				if (cnt_q == 2'h2) begin
					st_d = S_IDLE;
					if (mem_rdata[15:0] == op_q.in_cs && val_q == op_q.in_ip) begin
						ssp_d = tmp_q;                                    // [RULE5]
					end else begin
						fault_d = 1'b1;                                   // [RULE6]
						code_d  = FLT_FARRET;
						fip_d   = op_q.ip;
					end
				end else begin
					mreq_d = '{1'b1, 1'b0,
						ssp_q + ((cnt_q == 2'h0) ? CFGC_SLOT : (CFGC_SLOT + CFGC_SLOT)), 64'h0};
				end
			end
			S_RS_RD: if (mem_ack) begin
				if (!mem_rdata[CFGC_TOK_PREV] && mem_rdata[CFGC_TOK_MODE] == op_q.mode64 &&
					old_ptr == op_q.addr + CFGC_SLOT && op_q.addr[2:0] == 3'h0) begin // [RULE8]
					tmp_d  = op_q.addr;
					mreq_d = '{1'b1, 1'b1, op_q.addr,
						{ssp_q[63:2], 1'b1, op_q.mode64}};                // [RULE9] [RULE10]
					st_d   = S_RS_WR;
				end else begin
					fault_d = 1'b1;                                       // [RULE25]
					code_d  = FLT_TOKEN;
					fip_d   = op_q.ip;
					st_d    = S_IDLE;
				end
			end
			S_RS_WR: if (mem_ack) begin
				ssp_d = tmp_q;                                            // [RULE7]
				st_d  = S_IDLE;
			end
			S_SP_RD: if (mem_ack) begin
				if (mem_rdata[CFGC_TOK_PREV] && mem_rdata[CFGC_TOK_MODE] == op_q.mode64) begin
					mreq_d = '{1'b1, 1'b1, {old_ptr[63:3], 3'h0} - CFGC_SLOT,
						{old_ptr[63:2], 1'b0, op_q.mode64}};              // [RULE12]
					st_d   = S_SP_WR;
				end else begin
					fault_d = 1'b1;                                       // [RULE25]
					code_d  = FLT_TOKEN;
					fip_d   = op_q.ip;
					st_d    = S_IDLE;
				end
			end
			S_SP_WR: if (mem_ack) begin
				ssp_d = ssp_q + CFGC_SLOT;                                // [RULE13]
				st_d  = S_IDLE;
			end
			default: st_d = S_IDLE;
		endcase
		opr_d = (st_d == S_IDLE);
	end

	// engine registers; ready is registered so it drops the cycle a step starts
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q     <= S_IDLE;
			op_q     <= '0;
			tmp_q    <= 64'h0;
			val_q    <= 64'h0;
			cnt_q    <= 2'h0;
			ssp_q    <= CFGC_SSP_RST;
			fip_q    <= 64'h0;
			code_q   <= FLT_NONE;
			trk_q[0] <= TRK_IDLE;                                         // [RULE18]
			trk_q[1] <= TRK_IDLE;
			ret_q    <= 1'b1;
			fault_q  <= 1'b0;
			mreq_q   <= '0;
			opr_q    <= 1'b1;
		end else begin
			st_q    <= st_d;
			op_q    <= op_d;
			tmp_q   <= tmp_d;
			val_q   <= val_d;
			cnt_q   <= cnt_d;
			ssp_q   <= ssp_d;
			fip_q   <= fip_d;
			code_q  <= code_d;
			trk_q   <= trk_d;
			ret_q   <= ret_d;
			fault_q <= fault_d;
			mreq_q  <= mreq_d;
			opr_q   <= opr_d;
		end
	end

	// outputs straight from flops
	assign s_awready  = awready_q;
	assign s_wready   = wready_q;
	assign s_bvalid   = bvalid_q;
	assign s_bresp    = bresp_q;
	assign s_arready  = arready_q;
	assign s_rvalid   = rvalid_q;
	assign s_rdata    = rdata_q;
	assign s_rresp    = rresp_q;
	assign op_ready   = opr_q;
	assign mreq       = mreq_q;
	assign fault      = fault_q;
	assign fault_code = code_q;
	assign fault_ip   = fip_q;
	assign ret_allow  = ret_q;

	// ****************************************************************
	// checks
	// ****************************************************************
	a_task_fmt: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE1]
		take && ss_en && trk_q[sel] == TRK_IDLE && op.kind == OP_TASK_CALL && op.vm86
		|=> fault_q && code_q == FLT_TASK && st_q == S_IDLE)
		else $error("task switch to virtual-8086 task not refused");
	a_tss_addr: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE2]
		st_q == S_TS_TSS && mreq_q.valid |-> mreq_q.addr == {32'h0, op_q.tss_base} + CFGC_TSS_SSP_OFF)
		else $error("segment pointer read at wrong offset");
	a_ssp_align: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE3]
		st_q == S_TS_TOK |-> tmp_q[2:0] == 3'h0)
		else $error("unaligned new shadow pointer accepted");
	a_push_end: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE4]
		st_q == S_TS_PUSH && mem_ack && cnt_q == 2'h2 |=> ssp_q == $past(tmp_q) && st_q == S_IDLE)
		else $error("pointer not set after three pushes");
	a_iret_fault: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE6]
		fault_q && code_q == FLT_FARRET |-> $past(st_q) == S_IR_POP)
		else $error("far return fault from wrong step");
	a_restore_ssp: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE7]
		st_q == S_RS_WR && mem_ack |=> ssp_q == $past(op_q.addr))
		else $error("restore did not move pointer to token");
	a_prev_tok: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE10]
		st_q == S_RS_WR && mreq_q.valid |-> mreq_q.we && mreq_q.wdata[1])
		else $error("previous-pointer token bit 1 clear");
	a_savep_pop: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE13]
		st_q == S_SP_WR && mem_ack |=> ssp_q == $past(ssp_q) + CFGC_SLOT)
		else $error("previous-pointer token not popped");
	a_land_fault: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE22]
		take && trk_en && trk_q[sel] == TRK_AWAIT && !land_ok && !op.hi_evt &&
		!ctrl_q[CFGC_CTRL_LEGACY] |=> fault_q && code_q == FLT_LANDING && fip_q == $past(op.ip))
		else $error("missing landing marker not faulted");
	a_bad_token: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE25]
		fault_q && code_q == FLT_TOKEN |-> $stable(ssp_q) && !mreq_q.valid)
		else $error("bad token changed state");
endmodule : cfgc_checker
`default_nettype wire

// file: shared/cfgc_pkg.sv
// cfgc_pkg: constants, enums and carrier structs for the control flow guard checker
package cfgc_pkg;
	// ****************************************************************
	// register map and fields
	// ****************************************************************
	localparam logic [7:0]  CFGC_OFF_CTRL    = 8'h00;
	localparam logic [7:0]  CFGC_OFF_SSP_LO  = 8'h04;
	localparam logic [7:0]  CFGC_OFF_SSP_HI  = 8'h08;
	localparam logic [7:0]  CFGC_OFF_STATUS  = 8'h0C;
	localparam logic [7:0]  CFGC_OFF_FIP_LO  = 8'h10;
	localparam int          CFGC_CTRL_SS_EN  = 0;
	localparam int          CFGC_CTRL_TRK_EN = 1;
	localparam int          CFGC_CTRL_LEGACY = 2;
	localparam logic [2:0]  CFGC_CTRL_RST    = 3'h0;
	localparam logic [63:0] CFGC_SSP_RST     = 64'h0;
	localparam logic [1:0]  CFGC_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  CFGC_RESP_SLVERR = 2'h2;
	// ****************************************************************
	// task segment and token layout
	// ****************************************************************
	localparam logic [63:0] CFGC_TSS_SSP_OFF = 64'h68;  // 104
	localparam logic [31:0] CFGC_TSS_MIN_SZ  = 32'h6C;  // 108
	localparam logic [63:0] CFGC_SLOT        = 64'h8;
	localparam int          CFGC_TOK_MODE    = 0;
	localparam int          CFGC_TOK_PREV    = 1;
	localparam logic [1:0]  CFGC_CPL_USER    = 2'h3;
	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [3:0] {
		OP_OTHER, OP_IND_BRANCH, OP_LAND32, OP_LAND64, OP_RESTORE,
		OP_SAVEPREV, OP_TASK_CALL, OP_TASK_IRET, OP_RET
	} cfgc_kind_t;
	typedef enum logic [2:0] {
		BR_RM, BR_FAR_MEM, BR_COND, BR_REL, BR_FAR_DIRECT, BR_ZERO_DISP
	} cfgc_form_t;
	typedef enum logic [2:0] {
		FLT_NONE, FLT_LANDING, FLT_FARRET, FLT_TOKEN, FLT_TASK
	} cfgc_flt_t;
	typedef enum logic [1:0] {TRK_IDLE, TRK_AWAIT} cfgc_trk_t;
	typedef struct packed {
		cfgc_kind_t  kind;
		cfgc_form_t  form;
		logic [1:0]  current_privilege_level;
		logic        mode64;
		logic        hi_evt;      // higher priority event at this boundary
		logic [63:0] ip;          // ip of this instruction
		logic [63:0] addr;        // restore operand
		logic [31:0] tss_base;
		logic [31:0] tss_size;
		logic        tss32;
		logic        vm86;
		logic [15:0] out_cs;
		logic [63:0] out_lip;
		logic [15:0] in_cs;
		logic [63:0] in_ip;
		logic        ret_spec;    // return address speculative only
		logic        ret_mismatch;
		logic        ret_pred;
	} cfgc_op_t;
	typedef struct packed {
		logic        valid;
		logic        we;
		logic [63:0] addr;
		logic [63:0] wdata;
	} cfgc_mreq_t;
endpackage : cfgc_pkg

// file: verif/cfgc_checker_tb.sv
// cfgc_checker_tb: directed bench for the control flow guard checker
`timescale 1ns/1ps
`default_nettype none
module cfgc_checker_tb
	import cfgc_pkg::*;
;
	// ********************
	// signals
	// ********************
	typedef struct packed {cfgc_form_t f; cfgc_kind_t k; logic m; logic e;} cfgc_row_t;
	logic        aclk = 1'b0, aresetn = 1'b0, slow = 1'b0, op_ready, mem_ack, fault, ret_allow;
	logic [7:0]  s_awaddr = 8'h0, s_araddr = 8'h0;
	logic [31:0] s_wdata = 32'h0, s_rdata;
	logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
	logic        s_arvalid = 1'b0, s_rready = 1'b0, op_valid = 1'b0;
	logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [1:0]  s_bresp, s_rresp;
	cfgc_op_t    op = '0, o;
	cfgc_mreq_t  mreq;
	logic [63:0] mem_rdata, fault_ip;
	cfgc_flt_t   fault_code;
	int          n_errors = 0, checked = 0, nf = 0, nb = 0;
	cfgc_row_t   rows [9] = '{'{BR_RM, OP_OTHER, 1'b1, 1'b1}, '{BR_RM, OP_LAND64, 1'b1, 1'b0},
		'{BR_FAR_MEM, OP_LAND32, 1'b1, 1'b1}, '{BR_FAR_MEM, OP_LAND32, 1'b0, 1'b0},
		'{BR_RM, OP_LAND64, 1'b0, 1'b1}, '{BR_COND, OP_OTHER, 1'b1, 1'b0},
		'{BR_REL, OP_OTHER, 1'b1, 1'b0}, '{BR_FAR_DIRECT, OP_OTHER, 1'b1, 1'b0},
		'{BR_ZERO_DISP, OP_OTHER, 1'b1, 1'b0}};
	// ********************
	// design and far side
	// ********************
	cfgc_checker i_dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(4'hF),
		.s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
		.s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
		.s_rready(s_rready), .op(op), .op_valid(op_valid), .op_ready(op_ready),
		.mreq(mreq), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .fault(fault),
		.fault_code(fault_code), .fault_ip(fault_ip), .ret_allow(ret_allow));
	cfgc_mem i_mem (.aclk(aclk), .aresetn(aresetn), .mreq(mreq), .slow(slow),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata));
	// clock, and a count of fault pulses so no pulse is missed between checks
	always #20 aclk = ~aclk;
	always @(posedge aclk) if (fault === 1'b1) nf <= nf + 1;
	// ********************
	// tasks
	// ********************
	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic test_done;
		$display("errors=%0d checked=%0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : test_done
	task automatic tmo(input int k);
		if (k >= 200) begin
			n_errors++;
			test_done();
		end
	endtask : tmo
	// write: address and data offered together, each dropped at its own take
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int k;
		@(posedge aclk);
		s_awaddr  <= a;
		s_wdata   <= d;
		s_awvalid <= 1'b1;
		s_wvalid  <= 1'b1;
		s_bready  <= 1'b1;
		for (k = 0; k < 200; k++) begin
			@(posedge aclk);
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
			if (s_bvalid) break;
		end
		s_bready <= 1'b0;
		tmo(k);
		chk(s_bresp, er);
	endtask : axw
	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int k;
		@(posedge aclk);
		s_araddr  <= a;
		s_arvalid <= 1'b1;
		s_rready  <= 1'b1;
		for (k = 0; k < 200; k++) begin
			@(posedge aclk);
			if (s_arready) s_arvalid <= 1'b0;
			if (s_rvalid) break;
		end
		s_rready <= 1'b0;
		tmo(k);
		chk(s_rdata, ed);
		chk(s_rresp, er);
	endtask : axr
	// offer one op, then wait until the engine is idle again plus margin for the pulse
	task automatic run(input cfgc_op_t x);
		int k;
		@(posedge aclk);
		op       <= x;
		op_valid <= 1'b1;
		for (k = 0; k < 200; k++) begin
			@(posedge aclk);
			if (op_ready === 1'b1) break;
		end
		op_valid <= 1'b0;
		tmo(k);
		for (k = 0; k < 200; k++) begin
			@(posedge aclk);
			if (op_ready === 1'b1) break;
		end
		tmo(k);
		repeat (2) @(posedge aclk);
	endtask : run
	task automatic expf(input logic e, input cfgc_flt_t c);
		chk(nf - nb, e);
		if (e) chk(fault_code, c);
		nb = nf;
	endtask : expf
	function automatic cfgc_op_t mk(input cfgc_kind_t k, input cfgc_form_t f,
		input logic [1:0] c, input logic m, input logic [63:0] ip);
		mk        = '0;
		mk.kind   = k;
		mk.form   = f;
		{mk.current_privilege_level, mk.mode64} = {c, m};
		mk.ip     = ip;
	endfunction : mk
	// ********************
	// sequence
	// ********************
	initial begin
		repeat (6) @(posedge aclk);
		chk({op_ready, ret_allow, mreq.valid, fault_code}, {3'b110, FLT_NONE});
		aresetn <= 1'b1;
		axr(CFGC_OFF_CTRL, 32'h0, CFGC_RESP_OKAY);
		axr(CFGC_OFF_STATUS, 32'h80, CFGC_RESP_OKAY);
		axr(8'h40, 32'h0, CFGC_RESP_SLVERR);
		axw(8'h40, 32'hFFFF, CFGC_RESP_SLVERR);
		axw(CFGC_OFF_CTRL, 32'h3, CFGC_RESP_OKAY);
		// branch form and follower pairs, the follower ip is the reported one
		for (int i = 0; i < 9; i++) begin
			run(mk(OP_IND_BRANCH, rows[i].f, 2'h3, rows[i].m, 64'h40));
			run(mk(rows[i].k, BR_RM, 2'h3, rows[i].m, 64'h100 + i));
			expf(rows[i].e, FLT_LANDING);
			if (rows[i].e) chk(fault_ip, 64'h100 + i);
		end
		axr(CFGC_OFF_SSP_LO, 32'h0, CFGC_RESP_OKAY);
		// user tracker waits while supervisor ops pass; higher event keeps the wait
		run(mk(OP_IND_BRANCH, BR_RM, 2'h3, 1'b1, 64'h40));
		axr(CFGC_OFF_STATUS, 32'h98, CFGC_RESP_OKAY);
		run(mk(OP_OTHER, BR_RM, 2'h0, 1'b1, 64'h50));
		o        = mk(OP_OTHER, BR_RM, 2'h3, 1'b1, 64'h60);
		o.hi_evt = 1'b1;
		run(o);
		expf(1'b0, FLT_NONE);
		run(mk(OP_OTHER, BR_RM, 2'h3, 1'b1, 64'h70));
		expf(1'b1, FLT_LANDING);
		axw(CFGC_OFF_CTRL, 32'h7, CFGC_RESP_OKAY);
		run(mk(OP_IND_BRANCH, BR_RM, 2'h0, 1'b1, 64'h40));
		run(mk(OP_OTHER, BR_RM, 2'h0, 1'b1, 64'h80));
		expf(1'b0, FLT_NONE);
		// restore then save-previous, tokens as in a switch from 1000 to 3FF8
		axw(CFGC_OFF_SSP_LO, 32'h1000, CFGC_RESP_OKAY);
		i_mem.m[64'h3FF8] = 64'h4001;
		o      = mk(OP_RESTORE, BR_RM, 2'h0, 1'b1, 64'h90);
		o.addr = 64'h3FF8;
		run(o);
		axr(CFGC_OFF_SSP_LO, 32'h3FF8, CFGC_RESP_OKAY);
		chk(i_mem.m[64'h3FF8], 64'h1003);
		slow <= 1'b1;
		run(mk(OP_SAVEPREV, BR_RM, 2'h0, 1'b1, 64'h94));
		chk(i_mem.m[64'hFF8], 64'h1001);
		axr(CFGC_OFF_SSP_LO, 32'h4000, CFGC_RESP_OKAY);
		expf(1'b0, FLT_NONE);
		o.addr   = 64'hFF8;
		o.mode64 = 1'b0;
		run(o);
		expf(1'b1, FLT_TOKEN);
		axr(CFGC_OFF_SSP_LO, 32'h4000, CFGC_RESP_OKAY);
		chk(i_mem.m[64'hFF8], 64'h1001);
		// task call: short segment, virtual-8086 and unaligned pointer refused, then a full push
		o          = mk(OP_TASK_CALL, BR_RM, 2'h3, 1'b0, 64'hA0);
		o.tss_base = 32'h200;
		o.tss_size = 32'h6B;
		o.tss32    = 1'b1;
		run(o);
		expf(1'b1, FLT_TASK);
		o.tss_size = 32'h6C;
		o.vm86     = 1'b1;
		run(o);
		expf(1'b1, FLT_TASK);
		o.vm86            = 1'b0;
		o.out_cs          = 16'h0010;
		o.out_lip         = 64'h1234;
		i_mem.m[64'h268]  = 64'h8004;
		run(o);
		expf(1'b1, FLT_TASK);
		i_mem.m[64'h268]  = 64'h8000;
		i_mem.m[64'h8000] = 64'h8000;
		run(o);
		expf(1'b0, FLT_NONE);
		chk(i_mem.m[64'h7FF8], 64'h10);
		chk(i_mem.m[64'h7FF0], 64'h1234);
		chk(i_mem.m[64'h7FE8], 64'h4000);
		axr(CFGC_OFF_SSP_LO, 32'h7FE8, CFGC_RESP_OKAY);
		// return switch: wrong ip refused first, then the matching one
		o       = mk(OP_TASK_IRET, BR_RM, 2'h3, 1'b0, 64'hB0);
		o.in_cs = 16'h0010;
		o.in_ip = 64'h1235;
		run(o);
		expf(1'b1, FLT_FARRET);
		axr(CFGC_OFF_SSP_LO, 32'h7FE8, CFGC_RESP_OKAY);
		o.in_ip = 64'h1234;
		run(o);
		expf(1'b0, FLT_NONE);
		axr(CFGC_OFF_SSP_LO, 32'h4000, CFGC_RESP_OKAY);
		// every combination of return address conditions
		for (int j = 0; j < 8; j++) begin
			o = mk(OP_RET, BR_RM, 2'h3, 1'b1, 64'hC0);
			{o.ret_spec, o.ret_mismatch, o.ret_pred} = j[2:0];
			run(o);
			chk(ret_allow, !((j[2] | j[1]) && !j[0]));
		end
		test_done();
	end
endmodule : cfgc_checker_tb
`default_nettype wire

// file: verif/cfgc_mem.sv
// cfgc_mem: behavioural shadow stack and task segment memory
`timescale 1ns/1ps
`default_nettype none
module cfgc_mem
	import cfgc_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// request side
	input  wire cfgc_mreq_t  mreq,
	input  wire logic        slow,
	output var  logic        mem_ack,
	output var  logic [63:0] mem_rdata
);
	logic [63:0] m [logic [63:0]];  // sparse words, bench preloads tokens
	logic        wait_q;
	// answer one cycle after valid, two when slow; data toggles outside the ack
	always @(posedge aclk) begin
		mem_ack   <= 1'b0;
		mem_rdata <= aresetn ? ~mem_rdata : 64'h0;
		wait_q    <= 1'b0;
		if (aresetn && mreq.valid && !mem_ack) begin
			if (slow && !wait_q) begin
				wait_q <= 1'b1;
			end else begin
				mem_ack <= 1'b1;
				if (mreq.we) begin
					m[mreq.addr] = mreq.wdata;
				end else begin
					mem_rdata <= m.exists(mreq.addr) ? m[mreq.addr] : ~mreq.addr;
				end
			end
		end
	end
endmodule : cfgc_mem
`default_nettype wire
